// file: verilog/adc_ctrl_map.svh
// Register offsets, field positions, reset values and timing counts of the converter control block
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH
`define ADC_STATUS_CONTROL_OFFSET 12'h000
`define ADC_RESULT_OFFSET 12'h004
`define ADC_CLOCK_DIVIDER_OFFSET 12'h008
`define ADC_IRQ_STATUS_OFFSET 12'h00C
`define ADC_IRQ_MASK_OFFSET 12'h010
`define ADC_CTRL_MODE_OFFSET 12'h014
`define SC_DONE_BIT 7
`define SC_IEN_BIT 6
`define SC_CONT_BIT 5
`define SC_SEL_MSB 4
`define SC_SEL_LSB 0
`define CD_DIV_MSB 7
`define CD_DIV_LSB 5
`define SEL_RESET 5'h1F
`define SEL_LINE0 5'h00
`define SEL_LINE1 5'h01
`define SEL_LINE4 5'h02
`define SEL_LINE5 5'h03
`define SEL_RESERVED 5'h1B
`define SEL_SUPPLY 5'h1D
`define SEL_GROUND 5'h1E
`define CONV_CYCLES 5'h10
`define IRQ_DONE_BIT 0
`define IRQ_REQ_BIT 1
`endif

// file: verilog/adc_ctrl_pkg.sv
// Types shared by the converter control block
package adc_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } conv_state_t;
  typedef enum logic [2:0] {
    IN_LINE0 = 3'b000,
    IN_LINE1 = 3'b001,
    IN_LINE4 = 3'b010,
    IN_LINE5 = 3'b011,
    IN_SUPPLY = 3'b100,
    IN_GROUND = 3'b101,
    IN_UNUSED = 3'b110,
    IN_NONE = 3'b111
  } input_sel_t;
endpackage : adc_ctrl_pkg

// file: verilog/adc_control_registers.sv
// Converter control block: registers, clock divider, conversion sequencer, interrupt
//
// What this block does
// - Done flag sets per conversion, cleared by result read
// - Interrupt enabled: done flag never set, reads zero
// - Interrupt request at end; cleared by read/write
// - Continuous bit repeats conversions, else one only
// - Reset clears enables, select all ones
// - Decode select codes into pins and references
// - All-ones select powers converter subsystem off
// - Unused select codes give undefined results
// - Eight-bit read-only result loaded per conversion
// - Prescaler divides bus clock by 1..16
// - Sixteen converter clocks, start after control write
// - Continuous mode overwrites unread results
// - Stop mode aborts conversion, resumes after exit
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.svh"
module adc_control_registers (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter core
  output logic converter_power_on,
  output logic [2:0] selected_analog_input,
  output logic sample_start,
  input wire logic [7:0] converter_data,
  // System
  input wire logic stop_mode,
  output logic irq
);

  logic [7:0] sc_reg, sc_next;
  logic [7:0] div_reg, div_next;
  logic [7:0] result_reg, result_next;
  logic done_reg, done_next;
  logic req_reg, req_next;
  logic [1:0] ists_reg, ists_next;
  logic [1:0] imask_reg, imask_next;
  logic [3:0] pre_reg, pre_next;
  logic [4:0] cnt_reg, cnt_next;
  logic pend_reg, pend_next;
  adc_ctrl_pkg::conv_state_t st_reg, st_next;
  logic [1:0] stop_sync_reg;
  logic [1:0] stop_sync_next;
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [11:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic do_write, do_read, sc_wr, res_rd, conv_done, cclk_en, stopped;
  logic [3:0] div_top;

  // Decodes the channel field into the multiplexer code
  function automatic adc_ctrl_pkg::input_sel_t decode_sel(input logic [4:0] sel);
    if (sel == `SEL_LINE0) decode_sel = adc_ctrl_pkg::IN_LINE0;
    else if (sel == `SEL_LINE1) decode_sel = adc_ctrl_pkg::IN_LINE1;
    else if (sel == `SEL_LINE4) decode_sel = adc_ctrl_pkg::IN_LINE4;
    else if (sel == `SEL_LINE5) decode_sel = adc_ctrl_pkg::IN_LINE5;
    else if (sel == `SEL_SUPPLY) decode_sel = adc_ctrl_pkg::IN_SUPPLY;
    else if (sel == `SEL_GROUND) decode_sel = adc_ctrl_pkg::IN_GROUND;
    else if (sel == `SEL_RESET) decode_sel = adc_ctrl_pkg::IN_NONE;
    else decode_sel = adc_ctrl_pkg::IN_UNUSED; // Reserved and unused: result undefined
  endfunction : decode_sel

  // Divider terminal count per prescaler code
  function automatic logic [3:0] div_limit(input logic [2:0] code);
    if (code[2]) div_limit = 4'hF;
    else if (code == 3'h3) div_limit = 4'h7;
    else if (code == 3'h2) div_limit = 4'h3;
    else if (code == 3'h1) div_limit = 4'h1;
    else div_limit = 4'h0;
  endfunction : div_limit

  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign sc_wr = do_write && awaddr_reg == `ADC_STATUS_CONTROL_OFFSET;
  assign res_rd = do_read && s_axi_araddr == `ADC_RESULT_OFFSET;
  assign stopped = stop_sync_reg[1];
  assign div_top = div_limit(div_reg[`CD_DIV_MSB:`CD_DIV_LSB]);
  assign cclk_en = pre_reg == div_top;
  assign conv_done = st_reg == adc_ctrl_pkg::ST_CONV && cclk_en && cnt_reg == `CONV_CYCLES - 5'h01;

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign converter_power_on = sc_reg[`SC_SEL_MSB:`SC_SEL_LSB] != `SEL_RESET;
  assign selected_analog_input = decode_sel(sc_reg[`SC_SEL_MSB:`SC_SEL_LSB]);
  assign sample_start = st_reg == adc_ctrl_pkg::ST_CONV && cnt_reg == 5'h00 && cclk_en;
  assign irq = |(ists_reg & imask_reg);

  // Bus slave
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      wdata_next = {24'h00_0000, s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00};
    end
    if (do_write) begin
      bvalid_next = 1'b1;
      bresp_next = (awaddr_reg == `ADC_RESULT_OFFSET || awaddr_reg > `ADC_CTRL_MODE_OFFSET
                    || awaddr_reg[1:0] != 2'b00) ? 2'b10 : 2'b00;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
    end
    if (do_read) begin
      rvalid_next = 1'b1;
      rresp_next = 2'b00;
      if (s_axi_araddr == `ADC_STATUS_CONTROL_OFFSET) rdata_next = {24'h00_0000, done_reg, sc_reg[6:0]};
      else if (s_axi_araddr == `ADC_RESULT_OFFSET) rdata_next = {24'h00_0000, result_reg};
      else if (s_axi_araddr == `ADC_CLOCK_DIVIDER_OFFSET) rdata_next = {24'h00_0000, div_reg};
      else if (s_axi_araddr == `ADC_IRQ_STATUS_OFFSET) rdata_next = {30'h0000_0000, ists_reg};
      else if (s_axi_araddr == `ADC_IRQ_MASK_OFFSET) rdata_next = {30'h0000_0000, imask_reg};
      else if (s_axi_araddr == `ADC_CTRL_MODE_OFFSET) rdata_next = {30'h0000_0000, req_reg, st_reg != adc_ctrl_pkg::ST_IDLE};
      else begin
        rdata_next = 32'h0000_0000;
        rresp_next = 2'b10;
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // Registers, sequencer and flags
  always_comb begin
    sc_next = sc_reg;
    div_next = div_reg;
    result_next = result_reg;
    done_next = done_reg;
    req_next = req_reg;
    ists_next = ists_reg;
    imask_next = imask_reg;
    pre_next = cclk_en ? 4'h0 : pre_reg + 4'h1;
    cnt_next = cnt_reg;
    pend_next = pend_reg;
    st_next = st_reg;
    stop_sync_next = {stop_sync_reg[0], stop_mode};
    if (do_write) begin
      if (awaddr_reg == `ADC_STATUS_CONTROL_OFFSET) begin
        sc_next = {1'b0, wdata_reg[6:0]}; // Done bit position ignored on write
        req_next = 1'b0;
        pend_next = 1'b1; // Start waits for next converter clock edge
      end else if (awaddr_reg == `ADC_CLOCK_DIVIDER_OFFSET) begin
        div_next = {wdata_reg[7:5], 5'b0_0000};
      end else if (awaddr_reg == `ADC_IRQ_STATUS_OFFSET) begin
        ists_next = ists_reg & ~wdata_reg[1:0];
      end else if (awaddr_reg == `ADC_IRQ_MASK_OFFSET) begin
        imask_next = wdata_reg[1:0];
      end
    end
    if (res_rd) begin
      done_next = 1'b0;
      req_next = 1'b0;
    end
    // Any control write abandons the running conversion
    if (sc_wr) begin
      st_next = (wdata_reg[4:0] == `SEL_RESET) ? adc_ctrl_pkg::ST_OFF : adc_ctrl_pkg::ST_IDLE;
      cnt_next = 5'h00;
    end else if (stopped) begin
      // Abort without losing the request, so conversion resumes on exit
      if (st_reg == adc_ctrl_pkg::ST_CONV) begin
        st_next = adc_ctrl_pkg::ST_IDLE;
        pend_next = 1'b1;
      end
      cnt_next = 5'h00;
    end else begin
      case (st_reg)
        adc_ctrl_pkg::ST_OFF: begin
          pend_next = 1'b0;
        end
        adc_ctrl_pkg::ST_IDLE: begin
          if (pend_reg && cclk_en) begin
            st_next = adc_ctrl_pkg::ST_CONV;
            pend_next = 1'b0;
            cnt_next = 5'h00;
          end
        end
        adc_ctrl_pkg::ST_CONV: begin
          if (cclk_en) begin
            cnt_next = cnt_reg + 5'h01; // Sixteen converter clocks
          end
          if (conv_done) begin
            cnt_next = 5'h00;
            result_next = converter_data; // Overwrites unread data too
            // Continuous mode keeps going, single mode stops
            st_next = sc_reg[`SC_CONT_BIT] ? adc_ctrl_pkg::ST_CONV : adc_ctrl_pkg::ST_IDLE;
            if (sc_reg[`SC_IEN_BIT]) begin
              req_next = 1'b1;
            end else begin
              done_next = 1'b1; // Set wins over a same-cycle read
            end
          end
        end
        default: begin
          st_next = adc_ctrl_pkg::ST_OFF;
        end
      endcase
    end
    if (sc_next[`SC_IEN_BIT]) begin
      done_next = 1'b0;
    end
    if (conv_done) begin
      ists_next[`IRQ_DONE_BIT] = 1'b1;
    end
    if (conv_done && sc_reg[`SC_IEN_BIT]) begin
      ists_next[`IRQ_REQ_BIT] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sc_reg <= {3'b000, `SEL_RESET};
      div_reg <= 8'h00;
      result_reg <= 8'h00;
      done_reg <= 1'b0;
      req_reg <= 1'b0;
      ists_reg <= 2'b00;
      imask_reg <= 2'b00;
      pre_reg <= 4'h0;
      cnt_reg <= 5'h00;
      pend_reg <= 1'b0;
      st_reg <= adc_ctrl_pkg::ST_OFF;
      stop_sync_reg <= 2'b00;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'b00;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'b00;
    end else begin
      sc_reg <= sc_next;
      div_reg <= div_next;
      result_reg <= result_next;
      done_reg <= done_next;
      req_reg <= req_next;
      ists_reg <= ists_next;
      imask_reg <= imask_next;
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      pend_reg <= pend_next;
      st_reg <= st_next;
      stop_sync_reg <= stop_sync_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

endmodule : adc_control_registers
`default_nettype wire

// file: dv/adc_core_model.sv
// Behavioural converter core facing the control block
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
  // Clock
  input wire logic aclk,
  // Control from the block
  input wire logic converter_power_on,
  input wire logic [2:0] selected_analog_input,
  input wire logic sample_start,
  // Result to the block
  output logic [7:0] converter_data
);
  int starts = 0;
  logic [7:0] held = 8'h00;
  assign converter_data = held;
  always @(posedge aclk) begin
    if (sample_start) begin
      starts <= starts + 1;
      held <= {5'h14, selected_analog_input};
    end else if (!converter_power_on) begin
      // Powered-off core toggles so no stale value can pass for a result
      held <= ~held;
    end
  end
endmodule : adc_core_model
`default_nettype wire

// file: dv/adc_control_registers_asserts.sv
// Port checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.svh"
module adc_ctrl_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Read channel
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // Converter and system
  input wire logic converter_power_on,
  input wire logic [2:0] selected_analog_input,
  input wire logic sample_start,
  input wire logic stop_mode,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  off_select_a: assert property (!converter_power_on |-> selected_analog_input == 3'h7)
    else $error("input not parked while off");
  on_select_a: assert property (converter_power_on |-> selected_analog_input != 3'h7)
    else $error("input parked while on");
  off_quiet_a: assert property (!converter_power_on [*2] |-> !sample_start)
    else $error("start while off");
  stop_quiet_a: assert property (stop_mode [*5] |-> !sample_start)
    else $error("start during stop");
  start_gap_a: assert property (sample_start |=> !sample_start [*3])
    else $error("starts too close");
  result_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `ADC_RESULT_OFFSET
    |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000) else $error("result read wrong");
  done_ien_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `ADC_STATUS_CONTROL_OFFSET
    |=> !(s_axi_rdata[7] && s_axi_rdata[6])) else $error("done flag set with interrupt");
  reset_off_a: assert property ($rose(aresetn) |-> !converter_power_on && !irq)
    else $error("not off after reset");
endmodule : adc_ctrl_checker
bind adc_control_registers adc_ctrl_checker chk_i (.aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .converter_power_on(converter_power_on),
  .selected_analog_input(selected_analog_input), .sample_start(sample_start), .stop_mode(stop_mode), .irq(irq));
`default_nettype wire

// file: dv/adc_control_registers_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.svh"
module adc_control_registers_tb;
  localparam logic [11:0] SC = `ADC_STATUS_CONTROL_OFFSET;
  localparam logic [11:0] RES = `ADC_RESULT_OFFSET;
  localparam logic [11:0] DIV = `ADC_CLOCK_DIVIDER_OFFSET;
  localparam logic [11:0] MD = `ADC_CTRL_MODE_OFFSET;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, stp = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, rd_val;
  logic awr, wr_rdy, bv, arr, rv, pwr, start, irq;
  logic [1:0] bresp, rresp;
  logic [2:0] sel;
  logic [7:0] cdat;
  int miscompares = 0, total_checks = 0, n, s0;
  always #4 aclk = ~aclk;
  adc_control_registers dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .converter_power_on(pwr), .selected_analog_input(sel), .sample_start(start), .converter_data(cdat),
    .stop_mode(stp), .irq(irq));
  adc_core_model core (.aclk(aclk), .converter_power_on(pwr), .selected_analog_input(sel),
    .sample_start(start), .converter_data(cdat));
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    br <= 1'b0;
    chk("bresp", bresp, er);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [1:0] er);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rr <= 1'b0;
    rd_val = rdat;
    chk("rresp", rresp, er);
  endtask : rd
  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    rd(a, 2'b00);
    chk(what, rd_val, exp);
  endtask : rchk
  // Counts bus cycles between two converter starts
  task automatic gap;
    n = 0;
    @(posedge aclk iff start === 1'b1);
    do begin
      @(posedge aclk);
      n++;
    end while (start !== 1'b1);
  endtask : gap
  task automatic t_reset;
    rchk("ctrl", SC, 32'h0000_001F);
    rchk("result", RES, 32'h0000_0000);
    chk("power", pwr, 1'b0);
    rd(12'h020, 2'b10);
    wr(RES, 32'h0000_0055, 2'b10);
    rchk("result ro", RES, 32'h0000_0000);
  endtask : t_reset
  task automatic t_decode;
    logic [4:0] codes [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1D, 5'h1E, 5'h1B};
    for (int i = 0; i < 7; i++) begin
      wr(SC, 32'(codes[i]), 2'b00);
      chk("input", sel, i);
      chk("power", pwr, 1'b1);
    end
    wr(SC, 32'h0000_001F, 2'b00);
    chk("off", pwr, 1'b0);
  endtask : t_decode
  task automatic t_single;
    wr(DIV, 32'h0000_0000, 2'b00); // Converter clock kept inside its limits
    s0 = core.starts;
    wr(SC, 32'h0000_0000, 2'b00);
    rd_val = 0;
    for (int i = 0; i < 100 && rd_val[7] !== 1'b1; i++) rd(SC, 2'b00);
    chk("done", rd_val, 32'h0000_0080);
    rchk("result", RES, 32'h0000_00A0);
    repeat (60) @(posedge aclk);
    rchk("done clr", SC, 32'h0000_0000);
    chk("starts", core.starts - s0, 1);
  endtask : t_single
  task automatic t_irq;
    // Events left from earlier scenarios would raise the line at once
    wr(`ADC_IRQ_STATUS_OFFSET, 32'h0000_0003, 2'b00);
    wr(`ADC_IRQ_MASK_OFFSET, 32'h0000_0003, 2'b00);
    wr(SC, 32'h0000_0041, 2'b00); // Done bit position kept zero
    for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge aclk);
    chk("irq", irq, 1'b1);
    rchk("no done", SC, 32'h0000_0041);
    rchk("request", MD, 32'h0000_0002);
    rchk("result", RES, 32'h0000_00A1);
    rchk("req read", MD, 32'h0000_0000);
    wr(`ADC_IRQ_MASK_OFFSET, 32'h0000_0000, 2'b00);
    chk("masked", irq, 1'b0);
    wr(`ADC_IRQ_STATUS_OFFSET, 32'h0000_0003, 2'b00);
    s0 = core.starts;
    wr(SC, 32'h0000_0041, 2'b00);
    for (int i = 0; i < 200 && core.starts == s0; i++) @(posedge aclk);
    repeat (30) @(posedge aclk);
    wr(SC, 32'h0000_0041, 2'b00);
    rchk("req write", MD, 32'h0000_0001);
    rchk("status", `ADC_IRQ_STATUS_OFFSET, 32'h0000_0003);
  endtask : t_irq
  task automatic t_div;
    wr(SC, 32'h0000_0022, 2'b00);
    for (int k = 0; k < 8; k++) begin
      wr(DIV, 32'(k) << 5, 2'b00);
      gap(); // First gap spans the change and is discarded
      gap();
      chk("gap", n, 16 << (k > 4 ? 4 : k));
    end
    wr(DIV, 32'h0000_0000, 2'b00);
    rchk("overwrite", RES, 32'h0000_00A2);
  endtask : t_div
  task automatic t_stop;
    stp <= 1'b1;
    repeat (5) @(posedge aclk);
    s0 = core.starts;
    repeat (200) @(posedge aclk);
    chk("stopped", core.starts - s0, 0);
    stp <= 1'b0;
    repeat (60) @(posedge aclk);
    chk("resumed", core.starts > s0, 1);
    wr(SC, 32'h0000_001F, 2'b00);
    s0 = core.starts;
    repeat (60) @(posedge aclk);
    chk("off idle", core.starts - s0, 0);
    wr(SC, 32'h0000_0023, 2'b00);
    gap(); // First result after power-up is not used
    gap();
    rchk("after wake", RES, 32'h0000_00A3);
  endtask : t_stop
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  // Whole run needs about 5700 cycles; the margin covers slow answers
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_decode();
    t_single();
    t_irq();
    t_div();
    t_stop();
    report_and_stop();
  end
endmodule : adc_control_registers_tb
`default_nettype wire
